// ---- core/jpp_port.sv ----
// Operation
// - Port works only with interface fuse programmed and disable bit clear.
// - Disable bit set under external reset clears after two chip clocks; here clear comes five clocks after the pin.
// - All shift registers shift least significant bit first.
// - Four-bit instruction register selects the data register.
// - Run-Test/Idle generates internal clock pulses.
// - Code 0xC selects one-bit reset register; TAP not reset.
// - Reset register output unlatched; a one holds chip reset.
// - After reset register clears, hold reset for the time-out.
// - Code 0x4 selects sixteen-bit unlock register shifted in.
// - Update-DR enables programming only on exact signature match.
// - Unlock register clears on power-on reset.
// - Code 0x5 selects 15-bit command register, capture previous result.
// - Update-DR applies command; Run-Test/Idle pulse executes it.
// - Code 0x6 selects the low eight command bits as page data.
// - Page-load Update-DR copies byte, written within 11 TCK cycles.
// - Page-load updates alternate low then high byte.
// - Word address pre-increments before each low byte except the first.
// - Code 0x7 captures addressed flash byte, low then high.
// - Page-read post-increments address after every high byte.
module jpp_port #(
  parameter int TIMEOUT_CLKS = 16,
  parameter int ADDR_W = 16,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Test access port pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Device control
  input wire logic jtag_interface_fuse_i,
  input wire logic jtag_disable_bit_i,
  input wire logic ext_reset_n_i,
  output logic jtag_disable_clear_o,
  output logic chip_reset_o,
  output logic prog_enabled_o,
  // Flash command interface
  output logic [14:0] cmd_o,
  output logic cmd_strobe_o,
  output logic cmd_exec_o,
  input wire logic [14:0] cmd_result_i,
  // Page buffer write stream
  output logic page_valid_o,
  input wire logic page_ready_i,
  output logic page_high_o,
  output logic [7:0] page_data_o,
  output logic [ADDR_W-1:0] word_addr_o,
  input wire logic addr_load_i,
  input wire logic [ADDR_W-1:0] addr_value_i,
  // Flash read
  input wire logic [15:0] flash_word_i
);
  // Pin synchronisers; first stage read only by the second
  // Pin bundle order: clock, mode select, data in
  logic [2:0] tck_s1_reg;
  logic [2:0] tck_s2_reg;
  logic tck_d_reg;
  // Reset pin joins the same two-stage path
  logic nrst_s1_reg;
  logic nrst_s2_reg;
  always_ff @(posedge sys_clk_i) begin
    tck_s1_reg <= {tck_i, tms_i, tdi_i};
    tck_s2_reg <= tck_s1_reg;
    nrst_s1_reg <= ext_reset_n_i;
    nrst_s2_reg <= nrst_s1_reg;
  end
  wire logic tck_s = tck_s2_reg[2];
  wire logic tms_s = tck_s2_reg[1];
  wire logic tdi_s = tck_s2_reg[0];
  wire logic tck_rise = tck_s && !tck_d_reg;
  wire logic tck_fall = !tck_s && tck_d_reg;

  // Port gating by fuse and disable bit
  // Reset pin trusted only after both stages; clear lags pin by sync plus count
  logic [1:0] jtd_cnt_reg;
  wire logic port_on = jtag_interface_fuse_i && !(jtag_disable_bit_i && !jtag_disable_clear_o);
  wire logic ext_rst_held = !nrst_s2_reg;
  wire logic jtd_cnt_done = jtd_cnt_reg == 2'(jpp_pkg::JTD_CLEAR_CLKS);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      jtd_cnt_reg <= '0;
      jtag_disable_clear_o <= 1'b0;
    end else if (!jtag_disable_bit_i) begin
      jtd_cnt_reg <= '0;
      jtag_disable_clear_o <= 1'b0;
    end else if (ext_rst_held && !jtd_cnt_done) begin
      jtd_cnt_reg <= jtd_cnt_reg + 2'd1;
    end else if (jtd_cnt_done) begin
      jtag_disable_clear_o <= 1'b1;
    end
  end

  // TAP controller, advanced on TCK rising edges
  // TMS rides the same sync path as TCK, so no skew between them
  jpp_pkg::jpp_tap_t tap_reg;
  jpp_pkg::jpp_tap_t tap_next;
  always_comb begin
    tap_next = tap_reg;
    case (tap_reg)
      jpp_pkg::JPP_TLR: tap_next = tms_s ? jpp_pkg::JPP_TLR : jpp_pkg::JPP_RTI;
      jpp_pkg::JPP_RTI: tap_next = tms_s ? jpp_pkg::JPP_SEL_DR : jpp_pkg::JPP_RTI;
      jpp_pkg::JPP_SEL_DR: tap_next = tms_s ? jpp_pkg::JPP_SEL_IR : jpp_pkg::JPP_CAP_DR;
      jpp_pkg::JPP_CAP_DR: tap_next = tms_s ? jpp_pkg::JPP_EX1_DR : jpp_pkg::JPP_SH_DR;
      jpp_pkg::JPP_SH_DR: tap_next = tms_s ? jpp_pkg::JPP_EX1_DR : jpp_pkg::JPP_SH_DR;
      jpp_pkg::JPP_EX1_DR: tap_next = tms_s ? jpp_pkg::JPP_UPD_DR : jpp_pkg::JPP_PA_DR;
      jpp_pkg::JPP_PA_DR: tap_next = tms_s ? jpp_pkg::JPP_EX2_DR : jpp_pkg::JPP_PA_DR;
      jpp_pkg::JPP_EX2_DR: tap_next = tms_s ? jpp_pkg::JPP_UPD_DR : jpp_pkg::JPP_SH_DR;
      jpp_pkg::JPP_UPD_DR: tap_next = tms_s ? jpp_pkg::JPP_SEL_DR : jpp_pkg::JPP_RTI;
      jpp_pkg::JPP_SEL_IR: tap_next = tms_s ? jpp_pkg::JPP_TLR : jpp_pkg::JPP_CAP_IR;
      jpp_pkg::JPP_CAP_IR: tap_next = tms_s ? jpp_pkg::JPP_EX1_IR : jpp_pkg::JPP_SH_IR;
      jpp_pkg::JPP_SH_IR: tap_next = tms_s ? jpp_pkg::JPP_EX1_IR : jpp_pkg::JPP_SH_IR;
      jpp_pkg::JPP_EX1_IR: tap_next = tms_s ? jpp_pkg::JPP_UPD_IR : jpp_pkg::JPP_PA_IR;
      jpp_pkg::JPP_PA_IR: tap_next = tms_s ? jpp_pkg::JPP_EX2_IR : jpp_pkg::JPP_PA_IR;
      jpp_pkg::JPP_EX2_IR: tap_next = tms_s ? jpp_pkg::JPP_UPD_IR : jpp_pkg::JPP_SH_IR;
      jpp_pkg::JPP_UPD_IR: tap_next = tms_s ? jpp_pkg::JPP_SEL_DR : jpp_pkg::JPP_RTI;
      default: tap_next = jpp_pkg::JPP_TLR;
    endcase
  end

  // State, decoded per rising edge
  // Each strobe lasts one system clock per TCK rise
  wire logic step = tck_rise && port_on;
  wire logic in_cap_dr = step && tap_reg == jpp_pkg::JPP_CAP_DR;
  wire logic in_sh_dr = step && tap_reg == jpp_pkg::JPP_SH_DR;
  wire logic in_upd_dr = step && tap_reg == jpp_pkg::JPP_UPD_DR;
  wire logic in_sh_ir = step && tap_reg == jpp_pkg::JPP_SH_IR;
  wire logic in_upd_ir = step && tap_reg == jpp_pkg::JPP_UPD_IR;
  wire logic in_cap_ir = step && tap_reg == jpp_pkg::JPP_CAP_IR;
  wire logic in_rti = step && tap_reg == jpp_pkg::JPP_RTI;

  // State register; a disabled port parks the controller in reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !port_on) begin
      tap_reg <= jpp_pkg::JPP_TLR;
      tck_d_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck_s;
      if (step) begin
        tap_reg <= tap_next;
      end
    end
  end

  // Instruction shift and latch
  // Capture pattern ends in 01, as instruction scans expect
  logic [3:0] ir_sh_reg;
  logic [3:0] ir_reg;
  wire logic sel_rst = ir_reg == jpp_pkg::HOLD_IN_RESET_INSTR;
  wire logic sel_unl = ir_reg == jpp_pkg::PROGRAM_UNLOCK_INSTR;
  wire logic sel_cmd = ir_reg == jpp_pkg::PROGRAM_COMMAND_INSTR;
  wire logic sel_pld = ir_reg == jpp_pkg::PAGE_LOAD_INSTR;
  wire logic sel_prd = ir_reg == jpp_pkg::PAGE_READ_INSTR;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tap_reg == jpp_pkg::JPP_TLR) begin
      ir_sh_reg <= '0;
      ir_reg <= jpp_pkg::IR_RESET_VAL;
    end else if (in_cap_ir) begin
      ir_sh_reg <= jpp_pkg::IR_CAPTURE_VAL;
    end else if (in_sh_ir) begin
      ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
    end else if (in_upd_ir) begin
      ir_reg <= ir_sh_reg;
    end
  end

  // Reset bit: unlatched, drives chip reset directly, TAP stays alive
  // Time-out reloads while the bit is one, so it runs from the clear
  localparam int TMO_W = $clog2(TIMEOUT_CLKS + 1);
  logic rst_bit_reg;
  logic [TMO_W-1:0] tmo_reg;
  wire logic rst_shift = in_sh_dr && sel_rst;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rst_bit_reg <= 1'b0;
      tmo_reg <= '0;
      chip_reset_o <= 1'b0;
    end else begin
      if (rst_shift) begin
        rst_bit_reg <= tdi_s;
      end
      if (rst_bit_reg) begin
        tmo_reg <= TMO_W'(TIMEOUT_CLKS);
      end else if (tmo_reg != '0) begin
        tmo_reg <= tmo_reg - 1'b1;
      end
      chip_reset_o <= rst_bit_reg || tmo_reg != '0;
    end
  end

  // Unlock register and programming enable
  // Any mismatch, a cleared register too, locks programming again
  logic [15:0] unl_reg;
  wire logic unl_shift = in_sh_dr && sel_unl;
  wire logic unl_update = in_upd_dr && sel_unl;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      unl_reg <= jpp_pkg::UNLOCK_CLEAR;
      prog_enabled_o <= 1'b0;
    end else if (unl_shift) begin
      unl_reg <= {tdi_s, unl_reg[15:1]};
    end else if (unl_update) begin
      prog_enabled_o <= unl_reg == jpp_pkg::UNLOCK_SIGNATURE;
    end
  end

  // Command register; low byte doubles as the page data register
  // Capture and shift only when unlocked, so a locked port returns one stale bit
  logic [14:0] cmd_reg;
  logic high_reg;
  logic first_reg;
  logic sh_any;
  wire logic data_sel = sel_pld || sel_prd;
  wire logic [7:0] rd_byte = high_reg ? flash_word_i[15:8] : flash_word_i[7:0];
  assign sh_any = in_sh_dr && prog_enabled_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmd_reg <= '0;
    end else if (in_cap_dr && sel_cmd && prog_enabled_o) begin
      cmd_reg <= cmd_result_i;
    end else if (in_cap_dr && sel_prd && prog_enabled_o) begin
      cmd_reg[7:0] <= rd_byte;
    end else if (sh_any && sel_cmd) begin
      cmd_reg <= {tdi_s, cmd_reg[14:1]};
    end else if (sh_any && data_sel) begin
      cmd_reg[7:0] <= {tdi_s, cmd_reg[7:1]};
    end
  end

  // Command apply and execute pulse
  // Exec fires for every TCK rise spent in Run-Test/Idle while the command instruction is selected and programming is unlocked
  wire logic cmd_apply = in_upd_dr && sel_cmd && prog_enabled_o;
  wire logic cmd_fire = in_rti && sel_cmd && prog_enabled_o;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmd_o <= '0;
      cmd_strobe_o <= 1'b0;
      cmd_exec_o <= 1'b0;
    end else begin
      cmd_strobe_o <= cmd_apply;
      cmd_exec_o <= cmd_fire;
      if (cmd_apply) begin
        cmd_o <= cmd_reg;
      end
    end
  end

  // Byte alternation and word address for page load and read
  wire logic pld_upd = in_upd_dr && sel_pld && prog_enabled_o;
  wire logic prd_cap = in_cap_dr && sel_prd && prog_enabled_o;
  // Entering any instruction restarts at the low byte
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || in_upd_ir) begin
      high_reg <= 1'b0;
      first_reg <= 1'b1;
    end else if (pld_upd || prd_cap) begin
      high_reg <= !high_reg;
      first_reg <= 1'b0;
    end
  end
  // A load from the outside decoder wins over stepping
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      word_addr_o <= '0;
    end else if (addr_load_i) begin
      word_addr_o <= addr_value_i;
    end else if (pld_upd && !high_reg && !first_reg) begin
      word_addr_o <= word_addr_o + 1'b1;
    end else if (prd_cap && high_reg) begin
      word_addr_o <= word_addr_o + 1'b1;
    end
  end

  // Temporary byte into the FIFO; drained well inside 11 TCK periods
  jpp_pkg::jpp_page_word_t tmp_word;
  jpp_pkg::jpp_page_word_t tmp_reg;
  jpp_pkg::jpp_page_word_t fifo_out;
  logic fifo_ready;
  logic fifo_valid;
  logic tmp_valid_reg;
  assign tmp_word = '{high: high_reg, data: cmd_reg[7:0]};

  // Byte waits in the temporary register while the FIFO is full
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tmp_valid_reg <= 1'b0;
    end else if (pld_upd) begin
      tmp_valid_reg <= 1'b1;
    end else if (fifo_ready) begin
      tmp_valid_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (pld_upd) begin
      tmp_reg <= tmp_word;
    end
  end

  // Sixteen entries ride out a long stall of the page buffer
  wire logic page_take = fifo_valid && page_ready_i && !page_valid_o;
  jpp_fifo #(.WIDTH($bits(jpp_pkg::jpp_page_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(tmp_valid_reg),
    .in_ready_o(fifo_ready),
    .in_data_i(tmp_reg),
    .out_valid_o(fifo_valid),
    .out_ready_i(page_take),
    .out_data_o(fifo_out)
  );

  // Registered page write stream; one write per two clocks keeps valid a pulse
  // A byte is lost only if a new update lands while the FIFO is still full
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      page_valid_o <= 1'b0;
      page_high_o <= 1'b0;
      page_data_o <= '0;
    end else if (page_take) begin
      page_valid_o <= 1'b1;
      page_high_o <= fifo_out.high;
      page_data_o <= fifo_out.data;
    end else begin
      page_valid_o <= 1'b0;
    end
  end

  // TDO changes on falling TCK, driven only in shift states
  // Programmer samples on the rise, so TDO settles for half a period
  logic tdo_bit;
  assign tdo_bit = (tap_reg == jpp_pkg::JPP_SH_IR) ? ir_sh_reg[0] :
                   sel_rst ? rst_bit_reg :
                   sel_unl ? unl_reg[0] : cmd_reg[0];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !port_on) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= tdo_bit;
      tdo_oe_o <= tap_reg == jpp_pkg::JPP_SH_DR || tap_reg == jpp_pkg::JPP_SH_IR;
    end
  end
endmodule

// ---- core/jpp_pkg.sv ----
package jpp_pkg;
  // Instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_RESET_VAL = 4'hf;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [3:0] HOLD_IN_RESET_INSTR = 4'hc;
  localparam logic [3:0] PROGRAM_UNLOCK_INSTR = 4'h4;
  localparam logic [3:0] PROGRAM_COMMAND_INSTR = 4'h5;
  localparam logic [3:0] PAGE_LOAD_INSTR = 4'h6;
  localparam logic [3:0] PAGE_READ_INSTR = 4'h7;
  // Data register widths
  localparam int UNLOCK_W = 16;
  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'ha370;
  localparam logic [15:0] UNLOCK_CLEAR = 16'h0000;
  // Timing
  localparam int JTD_CLEAR_CLKS = 2;
  localparam int PAGE_WRITE_TCK = 11;
  localparam int SYNC_STAGES = 2;

  // TAP controller states
  typedef enum logic [3:0] {
    JPP_TLR, JPP_RTI, JPP_SEL_DR, JPP_CAP_DR, JPP_SH_DR, JPP_EX1_DR, JPP_PA_DR, JPP_EX2_DR,
    JPP_UPD_DR, JPP_SEL_IR, JPP_CAP_IR, JPP_SH_IR, JPP_EX1_IR, JPP_PA_IR, JPP_EX2_IR, JPP_UPD_IR
  } jpp_tap_t;

  // Page buffer write request
  typedef struct packed {
    logic high;
    logic [7:0] data;
  } jpp_page_word_t;
endpackage

// ---- core/jpp_fifo.sv ----
module jpp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire logic full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire logic empty = (wr_reg == rd_reg);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  // Honest flags straight from the pointers
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_reg[AW-1:0]];

  // Pointer update
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

  // Storage
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ---- verification/jpp_port_monitor.sv ----
module jpp_port_monitor #(
  parameter int TIMEOUT_CLKS = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Device control
  input wire logic jtag_interface_fuse_i,
  input wire logic jtag_disable_bit_i,
  input wire logic ext_reset_n_i,
  input wire logic tdo_oe_o,
  input wire logic jtag_disable_clear_o,
  input wire logic chip_reset_o,
  input wire logic prog_enabled_o,
  // Flash side
  input wire logic [14:0] cmd_o,
  input wire logic cmd_strobe_o,
  input wire logic cmd_exec_o,
  input wire logic page_valid_o,
  input wire logic page_high_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int hi_cnt_reg;
  logic last_hi_reg;
  // Length of the running reset pulse; which half was written last
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !chip_reset_o)
      hi_cnt_reg <= 0;
    else
      hi_cnt_reg <= hi_cnt_reg + 1;
    if (rst_i)
      last_hi_reg <= 1'b1;
    else if (page_valid_o)
      last_hi_reg <= page_high_o;
  end
  property p_oe_fuse; tdo_oe_o |-> jtag_interface_fuse_i; endproperty
  a_oe_fuse: assert property (p_oe_fuse) else $error("tdo driven with fuse off");
  property p_unlock_fuse; $rose(prog_enabled_o) |-> jtag_interface_fuse_i && !jtag_disable_bit_i; endproperty
  a_unlock_fuse: assert property (p_unlock_fuse) else $error("unlock while port off");
  property p_jtd_clear; (jtag_disable_bit_i && !ext_reset_n_i) [*6] |-> jtag_disable_clear_o; endproperty
  a_jtd_clear: assert property (p_jtd_clear) else $error("disable bit not cleared");
  property p_jtd_cause; $rose(jtag_disable_clear_o) |-> jtag_disable_bit_i; endproperty
  a_jtd_cause: assert property (p_jtd_cause) else $error("clear without disable bit");
  property p_timeout; $fell(chip_reset_o) |-> hi_cnt_reg >= TIMEOUT_CLKS; endproperty
  a_timeout: assert property (p_timeout) else $error("reset released too early");
  property p_cmd_lock; cmd_strobe_o || cmd_exec_o |-> prog_enabled_o; endproperty
  a_cmd_lock: assert property (p_cmd_lock) else $error("command while locked");
  property p_page_lock; page_valid_o |-> prog_enabled_o; endproperty
  a_page_lock: assert property (p_page_lock) else $error("page write while locked");
  property p_cmd_hold; !$stable(cmd_o) |-> cmd_strobe_o; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without strobe");
  property p_exec_pulse; cmd_exec_o |=> !cmd_exec_o; endproperty
  a_exec_pulse: assert property (p_exec_pulse) else $error("execute pulse too long");
  property p_page_alt; page_valid_o |-> page_high_o != last_hi_reg; endproperty
  a_page_alt: assert property (p_page_alt) else $error("byte halves not alternating");
  c_reset: cover property ($rose(chip_reset_o));
  c_cmd: cover property (cmd_strobe_o);
  c_page: cover property (page_valid_o && page_high_o);
endmodule

bind jpp_port jpp_port_monitor #(.TIMEOUT_CLKS(TIMEOUT_CLKS)) u_mon (.sys_clk_i, .rst_i, .jtag_interface_fuse_i,
  .jtag_disable_bit_i, .ext_reset_n_i, .tdo_oe_o, .jtag_disable_clear_o, .chip_reset_o, .prog_enabled_o, .cmd_o,
  .cmd_strobe_o, .cmd_exec_o, .page_valid_o, .page_high_o);

// ---- verification/jpp_programmer.sv ----
module jpp_programmer (
  // Pins toward the port, the only ones used
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // TCK rests low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One 160 ns TCK period, far below the chip clock
  task automatic pulse(input logic tms_v, input logic tdi_v, output logic tdo_v);
    tms_o = tms_v;
    tdi_o = tdi_v;
    #80 tck_o = 1'b1;
    tdo_v = tdo_i;
    #80 tck_o = 1'b0;
  endtask
  // Scan from Run-Test/Idle and back, least significant bit first both ways
  task automatic scan(input logic ir, input int n, input logic [15:0] d, output logic [15:0] q);
    logic t;
    q = 16'h0000;
    #3 pulse(1'b1, 1'b0, t);
    if (ir) begin
      pulse(1'b1, 1'b0, t);
    end
    pulse(1'b0, 1'b0, t);
    pulse(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, d[i], t);
      q[i] = t;
    end
    // Released data line shows the inverse of the last bit
    pulse(1'b1, ~d[n-1], t);
    pulse(1'b0, ~d[n-1], t);
  endtask
  // Five TMS ones reach Test-Logic-Reset, then idle
  task automatic tap_reset();
    logic t;
    #3 repeat (5) pulse(1'b1, 1'b0, t);
    pulse(1'b0, 1'b0, t);
  endtask
endmodule

// ---- verification/jtag_programming_port_bench.sv ----
module jtag_programming_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fuse = 1'b1, jtag_disable_bit = 1'b0, ext_n = 1'b1, ready = 1'b1, aload = 1'b0;
  logic [15:0] aval = 16'h0000, fword = 16'h0000, q;
  logic [14:0] cres = 15'h0000;
  logic [24:0] e;
  logic [24:0] wq[$];
  logic [16:0] rows[3] = '{17'h0a371, 17'h00000, 17'h1a370};
  wire tck, tms, tdi, tdo, tdo_oe, tdo_w, jclr, crst, pen, cstb, cexe, pval, phi;
  wire [14:0] cmd;
  wire [7:0] pdat;
  wire [15:0] waddr;
  int n_mismatch = 0, n_checks = 0, n_stb = 0, n_exe = 0, k;
  jpp_port #(.TIMEOUT_CLKS(200)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .jtag_interface_fuse_i(fuse), .jtag_disable_bit_i(jtag_disable_bit), .ext_reset_n_i(ext_n),
    .jtag_disable_clear_o(jclr), .chip_reset_o(crst), .prog_enabled_o(pen), .cmd_o(cmd), .cmd_strobe_o(cstb),
    .cmd_exec_o(cexe), .cmd_result_i(cres), .page_valid_o(pval), .page_ready_i(ready), .page_high_o(phi),
    .page_data_o(pdat), .word_addr_o(waddr), .addr_load_i(aload), .addr_value_i(aval), .flash_word_i(fword));
  jpp_programmer prog (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));
  // Undriven TDO idles high at the programmer
  assign tdo_w = tdo_oe ? tdo : 1'b1;
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Control register, flash array and logs of the far side
  always @(posedge sys_clk_i) begin
    if (jclr) jtag_disable_bit <= 1'b0;
    fword <= {waddr[7:0] ^ 8'h5a, waddr[7:0]};
    if (cstb) n_stb <= n_stb + 1;
    if (cexe) n_exe <= n_exe + 1;
    if (pval) wq.push_back({phi, pdat, waddr});
  end
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected flag at %0t: got %b", $time, got);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ir(input logic [3:0] c);
    prog.scan(1'b1, 4, {12'h000, c}, q);
  endtask
  task automatic dr(input int n, input logic [15:0] d);
    prog.scan(1'b0, n, d, q);
  endtask
  task automatic load_addr(input logic [15:0] a);
    @(posedge sys_clk_i);
    aload <= 1'b1;
    aval <= a;
    @(posedge sys_clk_i);
    aload <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk_bit(pen, 1'b0);
    chk_bit(crst | tdo_oe | pval, 1'b0);
    // Fuse off: the signature must not take
    @(posedge sys_clk_i) fuse <= 1'b0;
    ir(4'h4);
    dr(16, 16'ha370);
    chk_bit(pen, 1'b0);
    // Disable bit set, external reset low
    @(posedge sys_clk_i);
    fuse <= 1'b1;
    jtag_disable_bit <= 1'b1;
    ext_n <= 1'b0;
    for (k = 0; k < 10 && jclr !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk_bit(jclr, 1'b1);
    if (k == 10) wrap_up();
    @(posedge sys_clk_i) ext_n <= 1'b1;
    prog.tap_reset();
    // Part reset through the register before any unlock
    ir(4'hc);
    dr(1, 16'h0001);
    chk_bit(crst, 1'b1);
    dr(1, 16'h0000);
    chk_bit(crst, 1'b1);
    for (k = 0; k < 300 && crst !== 1'b0; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk_bit(crst, 1'b0);
    if (k == 300) wrap_up();
    // Locked: commands go nowhere
    ir(4'h5);
    dr(15, 16'h1a3c);
    chk_val(16'(n_stb), 16'h0000);
    foreach (rows[i]) begin
      ir(4'h4);
      dr(16, rows[i][15:0]);
      chk_bit(pen, rows[i][16]);
    end
    // Shifting a command returns the previous result
    @(posedge sys_clk_i) cres <= 15'h2b5c;
    ir(4'h5);
    k = n_exe;
    dr(15, 16'h1a3c);
    chk_val(q, 16'h2b5c);
    chk_val({1'b0, cmd}, 16'h1a3c);
    chk_val(16'(n_stb), 16'h0001);
    prog.pulse(1'b0, 1'b0, q[0]);
    prog.pulse(1'b0, 1'b0, q[0]);
    chk_val(16'(n_exe - k), 16'h0003);
    // Page load; the sink stalls for the last two bytes
    load_addr(16'h003e);
    ir(4'h6);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk_i) ready <= (i < 4);
      dr(8, 16'(17 * (i + 1)));
      chk_val(16'(wq.size()), 16'(i < 4 ? i + 1 : 4));
    end
    @(posedge sys_clk_i) ready <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    chk_val(16'(wq.size()), 16'h0006);
    foreach (wq[i]) begin
      e = wq[i];
      chk_val({7'h00, e[24:16]}, {7'h00, i[0], 8'(17 * (i + 1))});
      if (i < 4) chk_val(e[15:0], 16'(16'h003e + i / 2));
    end
    // Page read alternates halves, address steps after each high byte
    load_addr(16'h0010);
    ir(4'h7);
    for (int i = 0; i < 4; i++) begin
      dr(8, 16'h0000);
      chk_val(q, {8'h00, 8'(8'h10 + i / 2) ^ (i[0] ? 8'h5a : 8'h00)});
    end
    chk_val(waddr, 16'h0012);
    // Leave programming mode with the register cleared
    ir(4'h4);
    dr(16, 16'h0000);
    chk_bit(pen, 1'b0);
    wrap_up();
  end
endmodule
